// ### bsmle_data_mem.sv
// Data space memory with registered read data
`timescale 1ns/10ps
module bsmle_data_mem #(
    parameter int AW = 10,
    parameter int DW = 8
) (
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [AW-1:0] rd_addr,
    output logic [DW-1:0] rd_data
);

    logic [DW-1:0] mem_r [0:(1<<AW)-1];

    // Write port
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // Read port, data valid the cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rd_en) begin
            rd_data <= mem_r[rd_addr];
        end
    end

endmodule

// ### bsmle_defines.svh
// Constants for the bit, shift, move and load execution block
`ifndef BSMLE_DEFINES_SVH
`define BSMLE_DEFINES_SVH

// APB byte offsets
`define BSMLE_OFS_CMD 8'h00
`define BSMLE_OFS_STAT 8'h04
`define BSMLE_OFS_PC 8'h08
`define BSMLE_OFS_REG_SEL 8'h0c
`define BSMLE_OFS_REG_DATA 8'h10
`define BSMLE_OFS_IO_SEL 8'h14
`define BSMLE_OFS_IO_DATA 8'h18
`define BSMLE_OFS_MEM_ADDR 8'h1c
`define BSMLE_OFS_MEM_DATA 8'h20

// Command word fields and the status busy bit
`define BSMLE_CMD_OP_LSB 0
`define BSMLE_CMD_RD_LSB 8
`define BSMLE_CMD_RR_LSB 16
`define BSMLE_CMD_PTR_LSB 21
`define BSMLE_CMD_IMM_LSB 24
`define BSMLE_STAT_BUSY_BIT 8

// Status byte bit positions
`define BSMLE_FLG_C 0
`define BSMLE_FLG_Z 1
`define BSMLE_FLG_N 2
`define BSMLE_FLG_V 3
`define BSMLE_FLG_S 4
`define BSMLE_FLG_H 5
`define BSMLE_FLG_T 6
`define BSMLE_FLG_I 7

// Low register of each pointer pair
`define BSMLE_PTR_X_LO 5'h1a
`define BSMLE_PTR_Y_LO 5'h1c
`define BSMLE_PTR_Z_LO 5'h1e

// Reset values
`define BSMLE_RST_STATUS 8'h00
`define BSMLE_RST_PC 16'h0000
`define BSMLE_RST_BYTE 8'h00

`endif

// ### bsmle_exec.sv
// Execution unit for flag branches, bit ops, shifts, moves and indirect loads
`timescale 1ns/10ps
`include "bsmle_defines.svh"
module bsmle_exec #(
    parameter int MEM_AW = 10,
    parameter int IO_AW = 3
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic exec_busy,
    output logic [7:0] status_byte
);

    logic [7:0] rf_r [0:31];
    logic [7:0] io_r [0:(1<<IO_AW)-1];
    logic [7:0] status_r;
    logic [15:0] pc_r;
    bsmle_pkg::bsmle_state_t state_r;
    bsmle_pkg::bsmle_state_t state_nxt;
    logic [5:0] op_r;
    logic [4:0] rd_r;
    logic [4:0] rr_r;
    logic [1:0] ptr_r;
    logic [7:0] imm_r;
    logic [4:0] reg_sel_r;
    logic [IO_AW-1:0] io_sel_r;
    logic [15:0] mem_addr_r;
    logic [31:0] prdata_r;
    logic [7:0] mem_rdata;

    // Picks the low register of the selected pointer pair
    function automatic logic [4:0] ptr_base(input logic [1:0] sel);
        case (sel)
            2'd0: ptr_base = `BSMLE_PTR_X_LO;
            2'd1: ptr_base = `BSMLE_PTR_Y_LO;
            default: ptr_base = `BSMLE_PTR_Z_LO;
        endcase
    endfunction

    // Flags after a shift or rotate: Z, C, N, V; S, H, T, I kept
    function automatic logic [7:0] shift_flags(input logic [7:0] res, input logic cout, input logic [7:0] old);
        logic [7:0] f;
        f = old;
        f[`BSMLE_FLG_Z] = (res == 8'h00);
        f[`BSMLE_FLG_C] = cout;
        f[`BSMLE_FLG_N] = res[7];
        f[`BSMLE_FLG_V] = res[7] ^ cout;
        return f;
    endfunction

    // True for the indirect load family
    function automatic logic is_load(input logic [5:0] op);
        return (op == bsmle_pkg::OP_LOAD_INDIRECT) || (op == bsmle_pkg::OP_LOAD_INDIRECT_POST) ||
               (op == bsmle_pkg::OP_LOAD_INDIRECT_PRE) || (op == bsmle_pkg::OP_LOAD_WITH_OFFSET);
    endfunction

    // APB decode
    logic apb_setup;
    logic apb_access;
    logic addr_mapped;
    logic wr_blocked;
    logic wr_fire;
    assign apb_setup = psel & ~penable;
    assign apb_access = psel & penable;
    assign exec_busy = (state_r != bsmle_pkg::ST_IDLE);
    always_comb begin
        addr_mapped = 1'b1;
        wr_blocked = 1'b0;
        case (paddr[7:0])
            `BSMLE_OFS_CMD, `BSMLE_OFS_STAT, `BSMLE_OFS_PC, `BSMLE_OFS_REG_DATA,
            `BSMLE_OFS_IO_DATA, `BSMLE_OFS_MEM_DATA: wr_blocked = pwrite & exec_busy;
            `BSMLE_OFS_REG_SEL, `BSMLE_OFS_IO_SEL, `BSMLE_OFS_MEM_ADDR: wr_blocked = 1'b0;
            default: addr_mapped = 1'b0;
        endcase
        if (paddr[31:8] != 24'h000000) begin
            addr_mapped = 1'b0;
        end
    end
    assign pready = apb_access;
    assign pslverr = apb_access & (~addr_mapped | wr_blocked);
    assign wr_fire = apb_access & pwrite & addr_mapped & ~wr_blocked;
    assign prdata = prdata_r;
    assign status_byte = status_r;

    // Read data captured in the setup cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prdata_r <= 32'h00000000;
        end else if (apb_setup) begin
            case (paddr[7:0])
                `BSMLE_OFS_CMD: prdata_r <= {imm_r, 1'b0, ptr_r, rr_r, 3'h0, rd_r, 2'h0, op_r};
                `BSMLE_OFS_STAT: prdata_r <= {23'h000000, exec_busy, status_r};
                `BSMLE_OFS_PC: prdata_r <= {16'h0000, pc_r};
                `BSMLE_OFS_REG_SEL: prdata_r <= {27'h0000000, reg_sel_r};
                `BSMLE_OFS_REG_DATA: prdata_r <= {24'h000000, rf_r[reg_sel_r]};
                `BSMLE_OFS_IO_SEL: prdata_r <= 32'(io_sel_r);
                `BSMLE_OFS_IO_DATA: prdata_r <= {24'h000000, io_r[io_sel_r]};
                `BSMLE_OFS_MEM_ADDR: prdata_r <= {16'h0000, mem_addr_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    // Command latch and window selectors
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            op_r <= 6'h00;
            rd_r <= 5'h00;
            rr_r <= 5'h00;
            ptr_r <= 2'h0;
            imm_r <= 8'h00;
            reg_sel_r <= 5'h00;
            io_sel_r <= '0;
            mem_addr_r <= 16'h0000;
        end else if (wr_fire) begin
            case (paddr[7:0])
                `BSMLE_OFS_CMD: begin
                    op_r <= pwdata[`BSMLE_CMD_OP_LSB +: 6];
                    rd_r <= pwdata[`BSMLE_CMD_RD_LSB +: 5];
                    rr_r <= pwdata[`BSMLE_CMD_RR_LSB +: 5];
                    ptr_r <= pwdata[`BSMLE_CMD_PTR_LSB +: 2];
                    imm_r <= pwdata[`BSMLE_CMD_IMM_LSB +: 8];
                end
                `BSMLE_OFS_REG_SEL: reg_sel_r <= pwdata[4:0];
                `BSMLE_OFS_IO_SEL: io_sel_r <= pwdata[IO_AW-1:0];
                `BSMLE_OFS_MEM_ADDR: mem_addr_r <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // Operands and pointer arithmetic
    logic [7:0] opa;
    logic [7:0] opb;
    logic [4:0] pbase;
    logic [15:0] ptr_val;
    logic [15:0] ptr_new;
    logic [15:0] load_addr;
    logic [2:0] bit_idx;
    logic [IO_AW-1:0] io_idx;
    logic br_taken;
    logic long_op;
    assign opa = rf_r[rd_r];
    assign opb = rf_r[rr_r];
    assign pbase = ptr_base(ptr_r);
    assign ptr_val = {rf_r[pbase | 5'h01], rf_r[pbase]};
    assign bit_idx = imm_r[2:0];
    assign io_idx = rr_r[IO_AW-1:0];
    assign br_taken = ((op_r == bsmle_pkg::OP_BRANCH_IRQ_ON) & status_r[`BSMLE_FLG_I]) |
                      ((op_r == bsmle_pkg::OP_BRANCH_IRQ_OFF) & ~status_r[`BSMLE_FLG_I]);
    assign long_op = br_taken | (op_r == bsmle_pkg::OP_IO_BIT_RAISE) | (op_r == bsmle_pkg::OP_IO_BIT_DROP) |
                     is_load(op_r);

    // Load address and pointer update, 16-bit wrap
    always_comb begin
        load_addr = ptr_val;
        ptr_new = ptr_val;
        case (op_r)
            bsmle_pkg::OP_LOAD_INDIRECT_POST: ptr_new = ptr_val + 16'h0001;
            bsmle_pkg::OP_LOAD_INDIRECT_PRE: begin
                ptr_new = ptr_val - 16'h0001;
                load_addr = ptr_new;
            end
            bsmle_pkg::OP_LOAD_WITH_OFFSET: load_addr = ptr_val + {10'h000, imm_r[5:0]};
            default: ;
        endcase
    end

    // Single-cycle result and next flags
    logic [7:0] res;
    logic [7:0] flags_nxt;
    logic wr_rd;
    always_comb begin
        res = opa;
        flags_nxt = status_r;
        wr_rd = 1'b0;
        case (op_r)
            bsmle_pkg::OP_SHIFT_LEFT_LOGICAL: begin
                res = {opa[6:0], 1'b0};
                flags_nxt = shift_flags(res, opa[7], status_r);
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
                res = {1'b0, opa[7:1]};
                flags_nxt = shift_flags(res, opa[0], status_r);
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_ROTATE_LEFT_VIA_CARRY: begin
                res = {opa[6:0], status_r[`BSMLE_FLG_C]};
                flags_nxt = shift_flags(res, opa[7], status_r);
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
                res = {status_r[`BSMLE_FLG_C], opa[7:1]};
                flags_nxt = shift_flags(res, opa[0], status_r);
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_SHIFT_RIGHT_SIGNED: begin
                res = {opa[7], opa[7:1]};
                flags_nxt = shift_flags(res, opa[0], status_r);
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_NIBBLE_SWAP: begin
                res = {opa[3:0], opa[7:4]};
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_STATUS_BIT_RAISE: flags_nxt[bit_idx] = 1'b1;
            bsmle_pkg::OP_STATUS_BIT_DROP: flags_nxt[bit_idx] = 1'b0;
            bsmle_pkg::OP_BIT_TO_TRANSFER_FLAG: flags_nxt[`BSMLE_FLG_T] = opb[bit_idx];
            bsmle_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
                res[bit_idx] = status_r[`BSMLE_FLG_T];
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_REG_COPY: begin
                res = opb;
                wr_rd = 1'b1;
            end
            bsmle_pkg::OP_LOAD_CONSTANT: begin
                res = imm_r;
                wr_rd = 1'b1;
            end
            default: begin
                if (op_r[5]) begin
                    flags_nxt[op_r[2:0]] = ~op_r[3];
                end
            end
        endcase
    end

    // Sequencer: one cycle, or two for taken branches, I/O bits and loads
    always_comb begin
        case (state_r)
            bsmle_pkg::ST_IDLE: begin
                state_nxt = (wr_fire && paddr[7:0] == `BSMLE_OFS_CMD) ? bsmle_pkg::ST_EXEC : bsmle_pkg::ST_IDLE;
            end
            bsmle_pkg::ST_EXEC: state_nxt = long_op ? bsmle_pkg::ST_FINISH : bsmle_pkg::ST_IDLE;
            bsmle_pkg::ST_FINISH: state_nxt = bsmle_pkg::ST_IDLE;
            default: state_nxt = bsmle_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_r <= bsmle_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Data memory read issued in the first load cycle
    logic in_exec;
    logic in_finish;
    assign in_exec = (state_r == bsmle_pkg::ST_EXEC);
    assign in_finish = (state_r == bsmle_pkg::ST_FINISH);

    bsmle_data_mem #(
        .AW(MEM_AW),
        .DW(8)
    ) u_data_mem (
        .ref_clk(ref_clk),
        .wr_en(wr_fire && paddr[7:0] == `BSMLE_OFS_MEM_DATA),
        .wr_addr(mem_addr_r[MEM_AW-1:0]),
        .wr_data(pwdata[7:0]),
        .rd_en(in_exec & is_load(op_r)),
        .rd_addr(load_addr[MEM_AW-1:0]),
        .rd_data(mem_rdata)
    );

    // Register file updates
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < 32; i++) begin
                rf_r[i] <= `BSMLE_RST_BYTE;
            end
        end else if (wr_fire && paddr[7:0] == `BSMLE_OFS_REG_DATA) begin
            rf_r[reg_sel_r] <= pwdata[7:0];
        end else if (in_exec) begin
            if (wr_rd) begin
                rf_r[rd_r] <= res;
            end
            if (op_r == bsmle_pkg::OP_REG_PAIR_COPY) begin
                rf_r[rd_r & 5'h1e] <= rf_r[rr_r & 5'h1e];
                rf_r[rd_r | 5'h01] <= rf_r[rr_r | 5'h01];
            end
            if (is_load(op_r)) begin
                rf_r[pbase] <= ptr_new[7:0];
                rf_r[pbase | 5'h01] <= ptr_new[15:8];
            end
        end else if (in_finish && is_load(op_r)) begin
            rf_r[rd_r] <= mem_rdata;
        end
    end

    // Status byte
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            status_r <= `BSMLE_RST_STATUS;
        end else if (wr_fire && paddr[7:0] == `BSMLE_OFS_STAT) begin
            status_r <= pwdata[7:0];
        end else if (in_exec) begin
            status_r <= flags_nxt;
        end
    end

    // Program counter
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            pc_r <= `BSMLE_RST_PC;
        end else if (wr_fire && paddr[7:0] == `BSMLE_OFS_PC) begin
            pc_r <= pwdata[15:0];
        end else if (in_exec && !long_op) begin
            pc_r <= pc_r + 16'h0001;
        end else if (in_finish) begin
            pc_r <= br_taken ? pc_r + {{8{imm_r[7]}}, imm_r} + 16'h0001 : pc_r + 16'h0001;
        end
    end

    // I/O registers, bit forced in the second cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < (1 << IO_AW); i++) begin
                io_r[i] <= `BSMLE_RST_BYTE;
            end
        end else if (wr_fire && paddr[7:0] == `BSMLE_OFS_IO_DATA) begin
            io_r[io_sel_r] <= pwdata[7:0];
        end else if (in_finish && op_r == bsmle_pkg::OP_IO_BIT_RAISE) begin
            io_r[io_idx][bit_idx] <= 1'b1;
        end else if (in_finish && op_r == bsmle_pkg::OP_IO_BIT_DROP) begin
            io_r[io_idx][bit_idx] <= 1'b0;
        end
    end

    // Helper copies for the checks below
    logic [7:0] opa_q;
    logic [7:0] opb_q;
    logic [7:0] stat_q;
    logic [15:0] ptr_q;
    always_ff @(posedge ref_clk) begin
        opa_q <= opa;
        opb_q <= opb;
        stat_q <= status_r;
        ptr_q <= ptr_val;
    end

    // Checks
    a_branch_taken_pc: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_BRANCH_IRQ_ON && status_r[`BSMLE_FLG_I]
        |=> in_finish ##1 (pc_r == $past(pc_r, 2) + {{8{imm_r[7]}}, imm_r} + 16'h0001) && (status_r == stat_q))
        else $error("taken branch pc or flags wrong");
    a_io_bit_raise: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_IO_BIT_RAISE
        |=> ##1 io_r[io_idx][bit_idx] && status_r == $past(status_r, 2) && !exec_busy)
        else $error("io bit raise wrong");
    a_shift_left_res: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_SHIFT_LEFT_LOGICAL
        |=> rf_r[rd_r] == {opa_q[6:0], 1'b0} && status_r[`BSMLE_FLG_C] == opa_q[7])
        else $error("left shift result or carry wrong");
    a_rotate_right_c: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_ROTATE_RIGHT_VIA_CARRY
        |=> rf_r[rd_r] == {stat_q[`BSMLE_FLG_C], opa_q[7:1]} && status_r[`BSMLE_FLG_C] == opa_q[0])
        else $error("right rotate wrong");
    a_signed_shift: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_SHIFT_RIGHT_SIGNED
        |=> rf_r[rd_r] == {opa_q[7], opa_q[7:1]} && status_r[`BSMLE_FLG_Z] == (rf_r[rd_r] == 8'h00))
        else $error("signed shift wrong");
    a_swap_no_flags: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_NIBBLE_SWAP
        |=> rf_r[rd_r] == {opa_q[3:0], opa_q[7:4]} && $stable(status_r) && !exec_busy)
        else $error("nibble swap wrong");
    a_flag_dedicated: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r[5]
        |=> status_r[op_r[2:0]] == ~op_r[3] && (status_r ^ stat_q) == (stat_q ^ (stat_q & ~(8'h01 << op_r[2:0]))
            ^ ({7'h00, ~op_r[3]} << op_r[2:0])))
        else $error("dedicated flag op wrong");
    a_transfer_store: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_BIT_TO_TRANSFER_FLAG
        |=> status_r[`BSMLE_FLG_T] == opb_q[bit_idx] && status_r[5:0] == stat_q[5:0])
        else $error("bit to transfer flag wrong");
    a_load_post_ptr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_LOAD_INDIRECT_POST && pbase != (rd_r & 5'h1e)
        |=> ptr_val == ptr_q + 16'h0001 ##1 !exec_busy && status_r == $past(status_r, 2))
        else $error("post increment load wrong");
    a_load_pre_addr: assert property (@(posedge ref_clk) disable iff (sys_rst)
        in_exec && op_r == bsmle_pkg::OP_LOAD_INDIRECT_PRE |-> load_addr == ptr_val - 16'h0001 ##1 in_finish)
        else $error("pre decrement address wrong");

endmodule

// ### bsmle_exec_tb.sv
// Self-checking bench for the bit, shift, move and load execution block
`timescale 1ns/10ps
module bsmle_exec_tb;
    logic ref_clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, held = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, q;
    logic [7:0] status_byte, m;
    logic pready, pslverr, exec_busy, e;
    int n_fail = 0, comparisons = 0;
    // Block under test
    bsmle_exec dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exec_busy(exec_busy), .status_byte(status_byte));
    // Clock of 5 ns
    initial forever #2.5 ref_clk = ~ref_clk;
    // Compare one result
    task chk(input string nm, input logic [31:0] x, g);
        comparisons++;
        if (g !== x) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask
    // APB transfer; hold keeps psel up for a back-to-back follower
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic hold = 1'h0);
        if (!held) @(posedge ref_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'h1;
        do @(posedge ref_clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        held = hold;
        penable <= 1'h0;
        if (!hold) psel <= 1'h0;
    endtask
    // Register file access through the selector
    task wreg(input logic [4:0] r, input logic [7:0] v);
        apb(1'h1, 8'h0c, {27'h0, r});
        apb(1'h1, 8'h10, {24'h0, v});
    endtask
    task creg(input logic [4:0] r, input logic [7:0] v);
        apb(1'h1, 8'h0c, {27'h0, r});
        apb(1'h0, 8'h10, 32'h0);
        chk("register", {24'h0, v}, q);
    endtask
    // Run one operation: status s0 before, length c cycles, status s1 after
    task op(input logic [5:0] o, input int c, input logic [7:0] s0, s1, input logic [4:0] d = 5'h0,
        r = 5'h0, input logic [1:0] p = 2'h0, input logic [7:0] k = 8'h0);
        apb(1'h1, 8'h04, {24'h0, s0});
        apb(1'h1, 8'h00, {k, 1'h0, p, r, 3'h0, d, 2'h0, o});
        repeat (c) @(posedge ref_clk);
        chk("busy", 32'h1, {31'h0, exec_busy});
        @(posedge ref_clk);
        chk("idle", 32'h0, {31'h0, exec_busy});
        apb(1'h0, 8'h04, 32'h0);
        chk("status", {24'h0, s1}, q);
        chk("status pins", {24'h0, s1}, {24'h0, status_byte});
    endtask
    // Shift class on register 3 with carry and sign set beforehand
    task alu(input logic [5:0] o, input logic [7:0] v, r, s);
        wreg(5'h3, v);
        op(o, 1, 8'h11, s, 5'h3);
        creg(5'h3, r);
    endtask
    // Interrupt flag branch and the program counter after it
    task br(input logic [5:0] o, input logic [7:0] s, k, input logic [15:0] pc, input int c);
        op(o, c, s, s, 5'h0, 5'h0, 2'h0, k);
        apb(1'h0, 8'h08, 32'h0);
        chk("pc", {16'h0, pc}, q);
    endtask
    // Counts and verdict
    task print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog against a hang
    initial begin
        #200000;
        n_fail++;
        print_verdict();
    end
    // Test sequence
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'h0;
        apb(1'h0, 8'h04, 32'h0);
        chk("reset status", 32'h0, q);
        apb(1'h0, 8'h24, 32'h0);
        chk("unmapped", 32'h1, {31'h0, e});
        $display("test reset done");
        alu(6'h05, 8'h81, 8'h02, 8'h19);
        alu(6'h06, 8'h01, 8'h00, 8'h1b);
        alu(6'h07, 8'h40, 8'h81, 8'h1c);
        alu(6'h08, 8'h01, 8'h80, 8'h15);
        alu(6'h09, 8'h81, 8'hc0, 8'h15);
        alu(6'h0a, 8'h3c, 8'hc3, 8'h11);
        $display("test shifts done");
        for (int i = 0; i < 8; i++) begin
            for (int j = 0; j < 4; j++) begin
                m = 8'h1 << i;
                op(j[1] ? {2'h2, j[0], i[2:0]} : 6'h0b + 6'(j[0]), 1, j[0] ? 8'hff : 8'h0, j[0] ? ~m : m,
                    5'h0, 5'h0, 2'h0, 8'(i));
            end
        end
        $display("test flags done");
        wreg(5'h5, 8'h20);
        op(6'h0d, 1, 8'hbf, 8'hff, 5'h0, 5'h5, 2'h0, 8'h5);
        op(6'h0e, 1, 8'h40, 8'h40, 5'h6, 5'h0, 2'h0, 8'h5);
        creg(5'h6, 8'h20);
        wreg(5'h2, 8'h12);
        wreg(5'h3, 8'h34);
        op(6'h0f, 1, 8'h5a, 8'h5a, 5'h7, 5'h3);
        creg(5'h7, 8'h34);
        op(6'h10, 1, 8'h5a, 8'h5a, 5'h8, 5'h2);
        creg(5'h8, 8'h12);
        creg(5'h9, 8'h34);
        op(6'h11, 1, 8'h5a, 8'h5a, 5'h10, 5'h0, 2'h0, 8'ha5);
        creg(5'h10, 8'ha5);
        $display("test moves done");
        apb(1'h1, 8'h1c, 32'hffff);
        apb(1'h1, 8'h20, 32'h11);
        apb(1'h1, 8'h1c, 32'h0);
        apb(1'h1, 8'h20, 32'h44);
        apb(1'h1, 8'h1c, 32'h5);
        apb(1'h1, 8'h20, 32'h33);
        wreg(5'h1a, 8'hff);
        wreg(5'h1b, 8'hff);
        op(6'h13, 2, 8'h5a, 8'h5a, 5'h1);
        creg(5'h1, 8'h11);
        creg(5'h1b, 8'h00);
        creg(5'h1a, 8'h00);
        op(6'h12, 2, 8'h5a, 8'h5a, 5'h1, 5'h0, 2'h2);
        creg(5'h1, 8'h44);
        op(6'h14, 2, 8'h5a, 8'h5a, 5'h1, 5'h0, 2'h1);
        creg(5'h1, 8'h11);
        creg(5'h1d, 8'hff);
        op(6'h15, 2, 8'h5a, 8'h5a, 5'h1, 5'h0, 2'h2, 8'h5);
        creg(5'h1, 8'h33);
        creg(5'h1e, 8'h00);
        $display("test loads done");
        apb(1'h1, 8'h08, 32'h100);
        br(6'h01, 8'h80, 8'hfe, 16'h00ff, 2);
        br(6'h02, 8'h80, 8'h10, 16'h0100, 1);
        br(6'h02, 8'h00, 8'h10, 16'h0111, 2);
        br(6'h01, 8'h00, 8'h10, 16'h0112, 1);
        br(6'h00, 8'h5a, 8'h10, 16'h0113, 1);
        $display("test branches done");
        apb(1'h1, 8'h14, 32'h2);
        apb(1'h1, 8'h18, 32'h5a);
        apb(1'h1, 8'h00, {16'h0002, 16'h0003}, 1'h1);
        apb(1'h1, 8'h18, 32'hff);
        chk("refused", 32'h1, {31'h0, e});
        apb(1'h0, 8'h18, 32'h0);
        chk("io", 32'h5b, q);
        op(6'h04, 2, 8'h3c, 8'h3c, 5'h0, 5'h2, 2'h0, 8'h6);
        apb(1'h0, 8'h18, 32'h0);
        chk("io", 32'h1b, q);
        apb(1'h0, 8'h00, 32'h0);
        chk("command", 32'h06020004, q);
        $display("test io done");
        sys_rst <= 1'h1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'h0;
        apb(1'h0, 8'h08, 32'h0);
        chk("pc after reset", 32'h0, q);
        chk("status after reset", 32'h0, {24'h0, status_byte});
        creg(5'h10, 8'h00);
        $display("test second reset done");
        print_verdict();
    end
endmodule

// ### bsmle_pkg.sv
// Types for the bit, shift, move and load execution block
package bsmle_pkg;

    // Operation codes; codes 6'h20..6'h3f are dedicated flag ops {drop, s}, bit 4 ignored
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_BRANCH_IRQ_ON = 6'h01,
        OP_BRANCH_IRQ_OFF = 6'h02,
        OP_IO_BIT_RAISE = 6'h03,
        OP_IO_BIT_DROP = 6'h04,
        OP_SHIFT_LEFT_LOGICAL = 6'h05,
        OP_SHIFT_RIGHT_LOGICAL = 6'h06,
        OP_ROTATE_LEFT_VIA_CARRY = 6'h07,
        OP_ROTATE_RIGHT_VIA_CARRY = 6'h08,
        OP_SHIFT_RIGHT_SIGNED = 6'h09,
        OP_NIBBLE_SWAP = 6'h0a,
        OP_STATUS_BIT_RAISE = 6'h0b,
        OP_STATUS_BIT_DROP = 6'h0c,
        OP_BIT_TO_TRANSFER_FLAG = 6'h0d,
        OP_TRANSFER_FLAG_TO_BIT = 6'h0e,
        OP_REG_COPY = 6'h0f,
        OP_REG_PAIR_COPY = 6'h10,
        OP_LOAD_CONSTANT = 6'h11,
        OP_LOAD_INDIRECT = 6'h12,
        OP_LOAD_INDIRECT_POST = 6'h13,
        OP_LOAD_INDIRECT_PRE = 6'h14,
        OP_LOAD_WITH_OFFSET = 6'h15,
        OP_FLAG_DEDICATED = 6'h20
    } bsmle_op_t;

    // Execution sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_EXEC = 3'b010,
        ST_FINISH = 3'b100
    } bsmle_state_t;

endpackage
